// ### bench/core_model.sv
// core side model: halt instruction and halt wake source
`timescale 1ns/1ns
`default_nettype none
module core_model
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cpu_tick,
  input wire logic go_halt,
  input wire logic go_wake,
  output logic halt_instr,
  output logic halt_wake
);
  // halt executes only on a core cycle, as one pulse
  always_ff @(posedge sys_clk)
  begin
    halt_instr <= !rst && go_halt && cpu_tick && !halt_instr;
    halt_wake <= !rst && go_wake;
  end
endmodule
`default_nettype wire

// ### bench/main_clock_rtc_beeper_tb.sv
// self-checking bench for the clock controller
`timescale 1ns/1ns
`default_nettype none
module main_clock_rtc_beeper_tb;
  localparam logic [5:0] CS = mcc_pkg::ADDR_CCS;
  localparam logic [5:0] BP = mcc_pkg::ADDR_BEEP;
  localparam int TB0 = 16, TB1 = 32, TB2 = 80, TB3 = 200;
  localparam int BH2 = 4, BH1 = 8, BH5 = 16;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [7:0] avs_writedata = 8'h00;
  logic [7:0] avs_readdata;
  logic avs_waitrequest, halt_instr, halt_wake, irq_req, cpu_tick;
  logic active_halt, full_halt, clock_output_sel, clock_output_pin, beep_sel, beep_pin;
  logic go_halt = 1'b0;
  logic go_wake = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] msk_q[$];
  logic [7:0] pe, pm;
  logic [15:0] seed = 16'h5419;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  int per[4] = '{TB0, TB1, TB2, TB3};
  int codes[4] = '{0, 2, 1, 3};

  always #5 sys_clk = ~sys_clk;

  main_clock_rtc_beeper #(.TB_PERIOD_0(TB0), .TB_PERIOD_1(TB1), .TB_PERIOD_2(TB2),
    .TB_PERIOD_3(TB3), .BEEP_HALF_2K(BH2), .BEEP_HALF_1K(BH1), .BEEP_HALF_500(BH5))
    i_main_clock_rtc_beeper (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .halt_instr(halt_instr), .halt_wake(halt_wake), .irq_req(irq_req),
    .cpu_tick(cpu_tick), .active_halt(active_halt), .full_halt(full_halt),
    .clock_output_sel(clock_output_sel), .clock_output_pin(clock_output_pin),
    .beep_sel(beep_sel), .beep_pin(beep_pin));

  core_model i_core_model (.sys_clk(sys_clk), .rst(rst), .cpu_tick(cpu_tick),
    .go_halt(go_halt), .go_wake(go_wake), .halt_instr(halt_instr), .halt_wake(halt_wake));

  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task summarize();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %0h seen %0h", what, e, g);
    end
  endtask

  // read data taken at the completing edge, against the oldest note
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      summarize();
    end
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0)
    begin
      pe = exp_q.pop_front();
      pm = msk_q.pop_front();
      chk("readdata", pe, avs_readdata & pm);
    end
  end

  // one access; for reads d is the expected value under mask m
  task bus(input logic wr, input logic [5:0] a, input logic [7:0] d, input logic [7:0] m);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    if (!wr)
    begin
      exp_q.push_back(d & m);
      msk_q.push_back(m);
    end
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge sys_clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask

  task wait_irq(output int t);
    @(posedge sys_clk);
    while (irq_req !== 1'b1)
      @(posedge sys_clk);
    t = cyc;
  endtask

  task pulse(input logic w);
    if (w)
      go_wake <= 1'b1;
    else
      go_halt <= 1'b1;
    @(posedge sys_clk);
    go_wake <= 1'b0;
    go_halt <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  task measure(input int n, output int tk, output int cr, output int bt);
    logic pc, pb;
    tk = 0;
    cr = 0;
    bt = 0;
    pc = clock_output_pin;
    pb = beep_pin;
    repeat (n)
    begin
      @(posedge sys_clk);
      tk += int'(cpu_tick === 1'b1);
      cr += int'(clock_output_pin === 1'b1 && pc === 1'b0);
      bt += int'(beep_pin !== pb);
      pc = clock_output_pin;
      pb = beep_pin;
    end
  endtask

  initial
  begin
    int t, last, prev, tk, cr, bt, e;
    logic [7:0] v;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    bus(0, CS, 8'h00, 8'hff);
    bus(0, BP, 8'h00, 8'hff);
    bus(1, 6'h10, 8'h5a, 8'h00);
    bus(0, 6'h10, 8'h00, 8'hff);
    $display("test reset done");
    repeat (4)
    begin
      seed = lfsr(seed);
      v = seed[7:0] & 8'hfc;
      bus(1, CS, v, 8'h00);
      bus(0, CS, v, 8'hfe);
      bus(1, BP, v & 8'h03, 8'h00);
      bus(0, BP, v & 8'h03, 8'hff);
    end
    $display("test registers done");
    for (int i = 0; i < 6; i++)
    begin
      v = (i < 4) ? (8'h90 | 8'(i << 5)) : ((i == 4) ? 8'h80 : 8'h10);
      e = (i < 4) ? (64 >> (i + 1)) : ((i == 4) ? 64 : 32);
      bus(1, CS, v, 8'h00);
      measure(32, tk, cr, bt);
      measure(64, tk, cr, bt);
      chk("cpu_tick", e, tk);
      chk("clock_out", (i == 5) ? 0 : ((i == 4) ? 32 : e), cr);
      chk("clock_output_sel", v[7], clock_output_sel);
    end
    $display("test cpu clock done");
    for (int c = 0; c < 4; c++)
    begin
      bus(1, BP, 8'(c), 8'h00);
      measure(32, tk, cr, bt);
      measure(96, tk, cr, bt);
      chk("beep_toggles", (c == 0) ? 0 : 96 / (2 << c), bt);
      chk("beep_sel", c != 0, beep_sel);
    end
    bus(1, BP, 8'h00, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk("beep_off", 0, beep_pin);
    $display("test beep done");
    bus(1, CS, 8'h0e, 8'h00);
    // a stale flag may meet a tick; two clears line up on a fresh one
    repeat (2)
    begin
      wait_irq(t);
      bus(0, CS, 8'h00, 8'h00);
    end
    wait_irq(last);
    prev = 3;
    for (int k = 0; k < 4; k++)
    begin
      bus(0, CS, 8'h01, 8'h01);
      chk("irq_cleared", 0, irq_req);
      bus(1, CS, 8'(codes[k] << 2) | 8'h02, 8'h00);
      wait_irq(t);
      chk("period", per[prev], t - last);
      last = t;
      prev = codes[k];
    end
    $display("test time base done");
    bus(1, CS, 8'h86, 8'h00);
    bus(1, BP, 8'h01, 8'h00);
    bus(0, CS, 8'h00, 8'h00);
    wait_irq(t);
    bus(0, CS, 8'h01, 8'h01);
    pulse(0);
    chk("active_halt", 1, active_halt);
    chk("full_halt", 0, full_halt);
    measure(8, tk, cr, bt);
    chk("halt_ticks", 0, tk);
    chk("halt_clock_out", 0, cr);
    chk("halt_beep", 2, bt);
    wait_irq(t);
    repeat (2) @(posedge sys_clk);
    chk("irq_exit", 0, active_halt);
    $display("test active halt done");
    bus(0, CS, 8'h01, 8'h01);
    bus(1, CS, 8'h84, 8'h00);
    pulse(0);
    chk("full_halt", 1, full_halt);
    chk("no_active_halt", 0, active_halt);
    measure(40, tk, cr, bt);
    chk("frozen_ticks", 0, tk);
    chk("frozen_beep", 0, bt);
    chk("no_irq", 0, irq_req);
    pulse(1);
    @(posedge sys_clk);
    chk("woken", 0, full_halt);
    bus(0, CS, 8'h84, 8'hfe);
    $display("test full halt done");
    summarize();
  end
endmodule
`default_nettype wire

// ### inc/div_if.sv
// control and output of one square-wave divider
`timescale 1ns/1ns
`default_nettype none
interface div_if #(parameter int W = 13);
  logic run;
  logic clr;
  logic [W-1:0] half;
  logic wave;
  logic rise;
  modport ctl (output run, clr, half, input wave, rise);
  modport div (input run, clr, half, output wave, rise);
endinterface
`default_nettype wire

// ### inc/mcc_pkg.sv
// constants, field layout and power mode type of the clock controller
// Overview of operation
// - Wait mode: unchanged, interrupt wakes device.
// - Active-halt: counter runs, registers frozen, interrupt exits.
// - Full halt: counter and registers frozen.
// - Interrupt request when flag and enable set.
// - Time-base interrupt never wakes from full halt.
// - Bit 7 routes cpu clock to pin.
// - No clock output during active-halt.
// - Divider field selects divide by 2..16.
// - Slow select applies divider, else oscillator rate.
// - Time-base field selects 16000..200000 cycle period.
// - New time base takes effect at period end.
// - Halt with enable set enters active-halt.
// - Flag set at period end, cleared by read.
// - Beep field selects off, 2k, 1k, 500 Hz.
// - Beep keeps toggling during active-halt.
// - Divided clock drives core and peripherals.
`default_nettype none
package mcc_pkg;
  localparam int ADDR_W = 6;
  localparam logic [5:0] ADDR_CCS = 6'h2c;
  localparam logic [5:0] ADDR_BEEP = 6'h2d;
  localparam logic [7:0] CCS_RESET = 8'h00;
  localparam logic [7:0] BEEP_RESET = 8'h00;
  localparam logic [7:0] BEEP_WMASK = 8'h03;
  localparam logic [7:0] CCS_WMASK = 8'hfe;
  localparam int BIT_MCO = 7;
  localparam int CP_MSB = 6;
  localparam int CP_LSB = 5;
  localparam int BIT_SMS = 4;
  localparam int TB_MSB = 3;
  localparam int TB_LSB = 2;
  localparam int BIT_OIE = 1;
  localparam int BIT_FLAG = 0;
  localparam int BC_MSB = 1;
  localparam int BC_LSB = 0;
  localparam logic [1:0] BC_OFF = 2'h0;
  localparam logic [1:0] BC_2K = 2'h1;
  localparam logic [1:0] BC_1K = 2'h2;
  localparam int TB_W = 18;
  localparam int TB_PERIOD_0 = 16000;
  localparam int TB_PERIOD_1 = 32000;
  localparam int TB_PERIOD_2 = 80000;
  localparam int TB_PERIOD_3 = 200000;
  localparam int DIV_W = 13;
  localparam int BEEP_HALF_2K = 2000;
  localparam int BEEP_HALF_1K = 4000;
  localparam int BEEP_HALF_500 = 8000;
  localparam logic [12:0] CPU_HALF_BASE = 13'h0001;
  typedef enum logic [1:0] {PM_RUN, PM_ACTIVE_HALT, PM_HALT} pmode_t;
endpackage
`default_nettype wire

// ### rtl/main_clock_rtc_beeper.sv
// clock controller: cpu prescaler, clock out, time base, beeper, power modes
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module main_clock_rtc_beeper #(
  parameter int TB_PERIOD_0 = mcc_pkg::TB_PERIOD_0,
  parameter int TB_PERIOD_1 = mcc_pkg::TB_PERIOD_1,
  parameter int TB_PERIOD_2 = mcc_pkg::TB_PERIOD_2,
  parameter int TB_PERIOD_3 = mcc_pkg::TB_PERIOD_3,
  parameter int BEEP_HALF_2K = mcc_pkg::BEEP_HALF_2K,
  parameter int BEEP_HALF_1K = mcc_pkg::BEEP_HALF_1K,
  parameter int BEEP_HALF_500 = mcc_pkg::BEEP_HALF_500
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [mcc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [7:0] avs_writedata,
  output logic [7:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic halt_instr,
  input wire logic halt_wake,
  output logic irq_req,
  output logic cpu_tick,
  output logic active_halt,
  output logic full_halt,
  output logic clock_output_sel,
  output logic clock_output_pin,
  output logic beep_sel,
  output logic beep_pin
);
  localparam int DW = mcc_pkg::DIV_W;

  if (BEEP_HALF_2K < 1 || BEEP_HALF_1K < 1 || BEEP_HALF_500 < 1
      || BEEP_HALF_2K >= 2**DW || BEEP_HALF_1K >= 2**DW || BEEP_HALF_500 >= 2**DW)
  begin : g_check
    $error("beep half periods do not fit the divider");
  end

  // register file
  logic [7:0] ccs_ff, nxt_ccs;
  logic [7:0] beep_ff, nxt_beep;
  logic [7:0] rdata_ff, nxt_rdata;
  logic ack_ff, nxt_ack;
  mcc_pkg::pmode_t pm_ff, nxt_pm;
  logic clkout_ff, nxt_clkout;
  logic tb_tick;
  logic req;
  logic take;
  logic rd_ccs_take;
  logic regs_frozen;

  div_if #(.W(DW)) cpu_div ();
  div_if #(.W(DW)) beep_div ();

  assign req = avs_read | avs_write;
  assign take = req & ack_ff;
  assign rd_ccs_take = take & avs_read & (avs_address == mcc_pkg::ADDR_CCS);
  assign regs_frozen = (pm_ff != mcc_pkg::PM_RUN);

  // bus slave: in run mode, one wait cycle, then the access completes
  always_comb
  begin
    nxt_ack = req & ~ack_ff & ~regs_frozen;
    nxt_rdata = rdata_ff;
    if (req & ~ack_ff)
    begin
      case (avs_address)
        mcc_pkg::ADDR_CCS: nxt_rdata = ccs_ff;
        mcc_pkg::ADDR_BEEP: nxt_rdata = beep_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // control/status and beep registers
  always_comb
  begin
    nxt_ccs = ccs_ff;
    nxt_beep = beep_ff;
    if (take & avs_write & (avs_address == mcc_pkg::ADDR_CCS))
      nxt_ccs = (avs_writedata & mcc_pkg::CCS_WMASK) | (ccs_ff & ~mcc_pkg::CCS_WMASK);
    if (take & avs_write & (avs_address == mcc_pkg::ADDR_BEEP))
      nxt_beep = avs_writedata & mcc_pkg::BEEP_WMASK;
    // clear only a flag that the read returned; a new timeout wins
    if (rd_ccs_take & rdata_ff[mcc_pkg::BIT_FLAG])
      nxt_ccs[mcc_pkg::BIT_FLAG] = 1'b0;
    if (tb_tick)
      nxt_ccs[mcc_pkg::BIT_FLAG] = 1'b1;
  end

  // power mode tracking
  always_comb
  begin
    nxt_pm = pm_ff;
    case (pm_ff)
      mcc_pkg::PM_RUN:
        if (halt_instr)
          nxt_pm = ccs_ff[mcc_pkg::BIT_OIE] ? mcc_pkg::PM_ACTIVE_HALT
                                            : mcc_pkg::PM_HALT;
      mcc_pkg::PM_ACTIVE_HALT:
        if (irq_req | halt_wake)
          nxt_pm = mcc_pkg::PM_RUN;
      mcc_pkg::PM_HALT:
        if (halt_wake)
          nxt_pm = mcc_pkg::PM_RUN;
      default: nxt_pm = mcc_pkg::PM_RUN;
    endcase
  end

  // cpu prescaler: half period 1 in normal mode, 2^code in slow mode
  always_comb
  begin
    cpu_div.run = (pm_ff == mcc_pkg::PM_RUN);
    cpu_div.clr = 1'b0;
    if (ccs_ff[mcc_pkg::BIT_SMS])
      cpu_div.half = mcc_pkg::CPU_HALF_BASE << ccs_ff[mcc_pkg::CP_MSB:mcc_pkg::CP_LSB];
    else
      cpu_div.half = mcc_pkg::CPU_HALF_BASE;
    nxt_clkout = ccs_ff[mcc_pkg::BIT_MCO] & cpu_div.wave
                 & (pm_ff != mcc_pkg::PM_ACTIVE_HALT);
  end

  // beeper keeps running in active-halt, frozen in full halt
  always_comb
  begin
    beep_div.run = (pm_ff != mcc_pkg::PM_HALT);
    beep_div.clr = (beep_ff[mcc_pkg::BC_MSB:mcc_pkg::BC_LSB] == mcc_pkg::BC_OFF);
    case (beep_ff[mcc_pkg::BC_MSB:mcc_pkg::BC_LSB])
      mcc_pkg::BC_2K: beep_div.half = DW'(BEEP_HALF_2K);
      mcc_pkg::BC_1K: beep_div.half = DW'(BEEP_HALF_1K);
      default: beep_div.half = DW'(BEEP_HALF_500);
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ccs_ff <= mcc_pkg::CCS_RESET;
      beep_ff <= mcc_pkg::BEEP_RESET;
      rdata_ff <= 8'h00;
      ack_ff <= 1'b0;
      pm_ff <= mcc_pkg::PM_RUN;
      clkout_ff <= 1'b0;
    end
    else
    begin
      ccs_ff <= nxt_ccs;
      beep_ff <= nxt_beep;
      rdata_ff <= nxt_rdata;
      ack_ff <= nxt_ack;
      pm_ff <= nxt_pm;
      clkout_ff <= nxt_clkout;
    end
  end

  time_base_counter #(
    .W(mcc_pkg::TB_W),
    .P0(TB_PERIOD_0),
    .P1(TB_PERIOD_1),
    .P2(TB_PERIOD_2),
    .P3(TB_PERIOD_3)
  ) u_tb (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(pm_ff != mcc_pkg::PM_HALT),
    .sel(ccs_ff[mcc_pkg::TB_MSB:mcc_pkg::TB_LSB]),
    .tick(tb_tick)
  );

  tone_divider u_cpu_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .d(cpu_div)
  );

  tone_divider u_beep_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .d(beep_div)
  );

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = ~ack_ff;
  assign irq_req = ccs_ff[mcc_pkg::BIT_FLAG] & ccs_ff[mcc_pkg::BIT_OIE];
  // core and peripheral enable at the cpu rate
  assign cpu_tick = (pm_ff == mcc_pkg::PM_RUN)
                    & (~ccs_ff[mcc_pkg::BIT_SMS] | cpu_div.rise);
  assign active_halt = (pm_ff == mcc_pkg::PM_ACTIVE_HALT);
  assign full_halt = (pm_ff == mcc_pkg::PM_HALT);
  assign clock_output_sel = ccs_ff[mcc_pkg::BIT_MCO];
  assign clock_output_pin = clkout_ff;
  assign beep_sel = (beep_ff[mcc_pkg::BC_MSB:mcc_pkg::BC_LSB] != mcc_pkg::BC_OFF);
  assign beep_pin = beep_div.wave;

  // cycles since the last beep rise while beeping in active-halt
  localparam int QW = DW + 1;
  logic [QW-1:0] beep_quiet_ff, nxt_beep_quiet;

  always_comb
  begin
    nxt_beep_quiet = QW'(beep_quiet_ff + 1'b1);
    if (!active_halt || !beep_sel || beep_div.rise)
      nxt_beep_quiet = '0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      beep_quiet_ff <= '0;
    else
      beep_quiet_ff <= nxt_beep_quiet;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_ahalt_entry;
    pm_ff == mcc_pkg::PM_RUN && halt_instr && ccs_ff[mcc_pkg::BIT_OIE]
      |=> active_halt && !full_halt;
  endproperty
  a_ahalt_entry: assert property (p_ahalt_entry)
    else $error("halt with enable set did not enter active-halt");

  property p_halt_entry;
    pm_ff == mcc_pkg::PM_RUN && halt_instr && !ccs_ff[mcc_pkg::BIT_OIE] |=> full_halt;
  endproperty
  a_halt_entry: assert property (p_halt_entry)
    else $error("halt with enable clear did not enter full halt");

  property p_no_tb_wake;
    full_halt && !halt_wake |=> full_halt;
  endproperty
  a_no_tb_wake: assert property (p_no_tb_wake)
    else $error("full halt left without a halt wake-up");

  property p_ahalt_exit;
    active_halt && irq_req |=> pm_ff == mcc_pkg::PM_RUN;
  endproperty
  a_ahalt_exit: assert property (p_ahalt_exit)
    else $error("time-base interrupt did not end active-halt");

  property p_irq;
    tb_tick && ccs_ff[mcc_pkg::BIT_OIE] && !take |=> irq_req;
  endproperty
  a_irq: assert property (p_irq)
    else $error("timeout with enable set raised no request");

  property p_read_clear;
    rd_ccs_take && rdata_ff[mcc_pkg::BIT_FLAG] && !tb_tick
      |=> !ccs_ff[mcc_pkg::BIT_FLAG];
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("reading the status did not clear the flag");

  property p_clkout_off;
    active_halt |=> !clock_output_pin;
  endproperty
  a_clkout_off: assert property (p_clkout_off)
    else $error("clock output active during active-halt");

  property p_regs_frozen;
    pm_ff != mcc_pkg::PM_RUN |=> $stable(ccs_ff[7:1]) && $stable(beep_ff);
  endproperty
  a_regs_frozen: assert property (p_regs_frozen)
    else $error("registers changed while halted");

  property p_counter_frozen;
    full_halt && $past(full_halt) |-> !tb_tick;
  endproperty
  a_counter_frozen: assert property (p_counter_frozen)
    else $error("time base ticked in full halt");

  property p_beep_ahalt;
    active_halt && beep_sel |-> beep_quiet_ff < {beep_div.half, 1'b0};
  endproperty
  a_beep_ahalt: assert property (p_beep_ahalt)
    else $error("beep stopped during active-halt");

  c_ahalt_wake: cover property (active_halt ##1 pm_ff == mcc_pkg::PM_RUN);
  c_flag_read: cover property (rd_ccs_take && rdata_ff[mcc_pkg::BIT_FLAG]);
  c_beep_edge: cover property (beep_div.rise);
  property p_flag_set;
    tb_tick |=> ccs_ff[mcc_pkg::BIT_FLAG];
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("period end did not set the timeout flag");

  property p_clkout_gpio;
    !clock_output_sel |=> !clock_output_pin;
  endproperty
  a_clkout_gpio: assert property (p_clkout_gpio)
    else $error("clock output driven with its select clear");

  c_slow_tick: cover property (ccs_ff[mcc_pkg::BIT_SMS] && cpu_tick);
  c_halt_wake: cover property (full_halt ##1 !full_halt);
endmodule
`default_nettype wire

// ### rtl/time_base_counter.sv
// periodic time-base counter with selection taken at period end
`timescale 1ns/1ns
`default_nettype none
module time_base_counter #(
  parameter int W = 18,
  parameter int P0 = 16000,
  parameter int P1 = 32000,
  parameter int P2 = 80000,
  parameter int P3 = 200000
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [1:0] sel,
  output logic tick
);
  if (P0 < 1 || P1 < 1 || P2 < 1 || P3 < 1 || P0 >= 2**W || P1 >= 2**W
      || P2 >= 2**W || P3 >= 2**W)
  begin : g_check
    $error("time base periods do not fit the counter");
  end

  logic [W-1:0] cnt_ff, nxt_cnt;
  logic [1:0] cur_sel_ff, nxt_cur_sel;
  logic tick_ff, nxt_tick;
  logic [W-1:0] last;

  always_comb
  begin
    case (cur_sel_ff)
      2'h0: last = W'(P0 - 1);
      2'h1: last = W'(P1 - 1);
      2'h2: last = W'(P2 - 1);
      default: last = W'(P3 - 1);
    endcase
    nxt_cnt = cnt_ff;
    nxt_cur_sel = cur_sel_ff;
    nxt_tick = 1'b0;
    if (run)
    begin
      if (cnt_ff >= last)
      begin
        nxt_cnt = '0;
        nxt_cur_sel = sel;
        nxt_tick = 1'b1;
      end
      else
        nxt_cnt = W'(cnt_ff + 1'b1);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cnt_ff <= '0;
      cur_sel_ff <= 2'h0;
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      cur_sel_ff <= nxt_cur_sel;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;
endmodule
`default_nettype wire

// ### rtl/tone_divider.sv
// square-wave divider toggling every half period
`timescale 1ns/1ns
`default_nettype none
module tone_divider
(
  input wire logic sys_clk,
  input wire logic rst,
  div_if.div d
);
  localparam int W = $bits(d.half);
  logic [W-1:0] cnt_ff, nxt_cnt;
  logic wave_ff, nxt_wave;
  logic rise_ff, nxt_rise;

  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_wave = wave_ff;
    nxt_rise = 1'b0;
    if (d.clr)
    begin
      nxt_cnt = '0;
      nxt_wave = 1'b0;
    end
    else if (d.run)
    begin
      if (cnt_ff >= W'(d.half - 1'b1))
      begin
        nxt_cnt = '0;
        nxt_wave = ~wave_ff;
        nxt_rise = ~wave_ff;
      end
      else
        nxt_cnt = W'(cnt_ff + 1'b1);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cnt_ff <= '0;
      wave_ff <= 1'b0;
      rise_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      wave_ff <= nxt_wave;
      rise_ff <= nxt_rise;
    end
  end

  assign d.wave = wave_ff;
  assign d.rise = rise_ff;
endmodule
`default_nettype wire
